// [fsp_ctrl.v]
// flash self-programming controller: apb registers, latches, sequencer
`include "fsp_defs.vh"

module fsp_ctrl #(
    parameter ROW_WORDS = 128,
    parameter PGM_CYC   = (`FSP_PGM_WORD_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS,
    parameter ERASE_CYC = (`FSP_ERASE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS
) (
    // clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rst,
    // apb slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output wire        o_pready,
    output wire        o_pslverr,
    output reg  [31:0] o_prdata,
    // core table port
    input  wire        i_tbl_req,
    input  wire        i_tbl_wr,
    input  wire        i_tbl_high,
    input  wire        i_tbl_byte,
    input  wire [15:0] i_tbl_ea,
    input  wire [15:0] i_tbl_wdata,
    output reg  [15:0] o_tbl_rdata,
    output reg         o_tbl_done,
    output reg         o_ecc_trap,
    output wire        o_cpu_stall,
    // flash array port
    output reg  [22:0] o_arr_addr,
    output reg  [30:0] o_arr_wdata,
    output reg         o_arr_prog,
    output reg         o_arr_read,
    output reg         o_arr_erase,
    output reg         o_arr_chip,
    input  wire [30:0] i_arr_rdata
);

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    localparam ST_IDLE  = 2'd0;
    localparam ST_PGM   = 2'd1;
    localparam ST_WAIT  = 2'd2;
    localparam ST_ERASE = 2'd3;

    localparam KEY_IDLE  = 2'd0;
    localparam KEY_HALF  = 2'd1;
    localparam KEY_ARMED = 2'd2;

    localparam [31:0] ROW_LAST   = ROW_WORDS - 1;
    localparam [31:0] PGM_LAST   = PGM_CYC - 1;
    localparam [31:0] ERASE_LAST = ERASE_CYC - 1;

    reg  [23:0] latch_mem [0:ROW_WORDS-1];

    reg         start_q;
    reg         permit_q;
    reg         err_q;
    reg  [3:0]  opsel_q;
    reg  [1:0]  key_q;
    reg  [15:0] tgt_lo_q;
    reg  [7:0]  tgt_up_q;
    reg  [7:0]  page_q;
    reg         ecc_fix_q;
    reg         ecc_dbl_q;
    reg  [1:0]  st_q;
    reg  [6:0]  idx_q;
    reg  [6:0]  left_q;
    reg  [15:0] wait_q;
    reg         wr_pend_q;
    reg         rd_pend_q;
    reg         rd_high_q;
    reg         rd_byte_q;
    reg         rd_odd_q;

    wire        apb_setup;
    wire        apb_wr;
    wire        hit;
    wire        op_ok;
    wire        start_try;
    wire        launch;
    wire [23:0] target;
    wire [23:0] tbl_addr;
    wire [6:0]  tbl_idx;
    wire        tbl_take;
    wire [6:0]  enc_chk;
    wire [23:0] dec_data;
    wire        dec_single;
    wire        dec_double;
    reg  [23:0] merged;
    reg  [15:0] rd_sel;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign apb_setup = i_psel && !i_penable;
    assign apb_wr    = i_psel && i_penable && i_pwrite;
    assign hit       = (i_paddr == `FSP_OFS_CTRL)   || (i_paddr == `FSP_OFS_KEY)  ||
                       (i_paddr == `FSP_OFS_TGT_LO) || (i_paddr == `FSP_OFS_TGT_UP) ||
                       (i_paddr == `FSP_OFS_PAGE)   || (i_paddr == `FSP_OFS_ECC);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;

    assign target    = {tgt_up_q, tgt_lo_q};
    assign op_ok     = (i_pwdata[3:0] == `FSP_OP_ERASE) || (i_pwdata[3:0] == `FSP_OP_ROW) ||
                       (i_pwdata[3:0] == `FSP_OP_DWORD) || (i_pwdata[3:0] == `FSP_OP_CHIP);
    assign start_try = apb_wr && (i_paddr == `FSP_OFS_CTRL) && i_pwdata[`FSP_CTRL_START]
                       && !start_q;
    // start only when unlocked, permitted and the code is implemented
    assign launch    = start_try && (key_q == KEY_ARMED) && i_pwdata[`FSP_CTRL_PERMIT]
                       && op_ok;
    assign o_cpu_stall = start_q;

    // read data, captured in the setup phase
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= `FSP_RST_WORD;
        end else if (apb_setup) begin
            case (i_paddr)
                `FSP_OFS_CTRL:   o_prdata <= {16'h0000, start_q, permit_q, err_q, 9'h000, opsel_q};
                `FSP_OFS_TGT_LO: o_prdata <= {16'h0000, tgt_lo_q};
                `FSP_OFS_TGT_UP: o_prdata <= {24'h000000, tgt_up_q};
                `FSP_OFS_PAGE:   o_prdata <= {24'h000000, page_q};
                `FSP_OFS_ECC:    o_prdata <= {30'h00000000, ecc_dbl_q, ecc_fix_q};
                default:         o_prdata <= `FSP_RST_WORD;       // key reads as zero
            endcase
        end
    end

    // ****************************************************************
    // control, key and address registers
    // ****************************************************************
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            permit_q <= 1'b0;
            opsel_q  <= 4'h0;
            err_q    <= 1'b0;
            key_q    <= KEY_IDLE;
            tgt_lo_q <= 16'h0000;
            tgt_up_q <= 8'h00;
            page_q   <= 8'h00;
        end else if (apb_wr) begin
            // any write breaks the unlock sequence unless it continues it
            key_q <= KEY_IDLE;
            case (i_paddr)
                `FSP_OFS_CTRL: begin
                    if (!start_q) begin
                        permit_q <= i_pwdata[`FSP_CTRL_PERMIT];
                        opsel_q  <= i_pwdata[`FSP_CTRL_OP_HI:0];
                    end
                    // failed start attempt sets the flag, set wins
                    err_q <= (start_try && !launch) || (i_pwdata[`FSP_CTRL_ERR] && err_q
                             && !launch);
                end
                `FSP_OFS_KEY: begin
                    if (i_pwdata[7:0] == `FSP_KEY_FIRST) begin
                        key_q <= KEY_HALF;
                    end else if (i_pwdata[7:0] == `FSP_KEY_SECOND && key_q == KEY_HALF) begin
                        key_q <= KEY_ARMED;
                    end
                end
                `FSP_OFS_TGT_LO: tgt_lo_q <= i_pwdata[15:0];
                `FSP_OFS_TGT_UP: tgt_up_q <= i_pwdata[7:0];
                `FSP_OFS_PAGE:   page_q   <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // ecc status, sticky, write one to clear, set wins
    // ****************************************************************
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ecc_fix_q <= 1'b0;
            ecc_dbl_q <= 1'b0;
        end else begin
            if (rd_pend_q && dec_single) begin
                ecc_fix_q <= 1'b1;
            end else if (apb_wr && i_paddr == `FSP_OFS_ECC && i_pwdata[`FSP_ECC_FIX]) begin
                ecc_fix_q <= 1'b0;
            end
            if (rd_pend_q && dec_double) begin
                ecc_dbl_q <= 1'b1;
            end else if (apb_wr && i_paddr == `FSP_OFS_ECC && i_pwdata[`FSP_ECC_DBL]) begin
                ecc_dbl_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // table port: latch writes and array reads
    // ****************************************************************
    assign tbl_addr = {page_q, i_tbl_ea};
    assign tbl_idx  = tbl_addr[7:1];
    assign tbl_take = i_tbl_req && !start_q && !launch && !wr_pend_q && !rd_pend_q;

    // merge a word or byte into the addressed latch
    always @* begin
        merged = latch_mem[tbl_idx];
        if (!i_tbl_high) begin
            if (!i_tbl_byte) begin
                merged[15:0] = i_tbl_wdata;
            end else if (tbl_addr[0]) begin
                merged[15:8] = i_tbl_wdata[7:0];
            end else begin
                merged[7:0] = i_tbl_wdata[7:0];
            end
        end else if (!i_tbl_byte || !tbl_addr[0]) begin
            merged[23:16] = i_tbl_wdata[7:0];
        end
    end

    // latches hold data until a program cycle, any order, last wins
    always @(posedge i_ref_clk) begin
        if (tbl_take && i_tbl_wr) begin
            latch_mem[tbl_idx] <= merged;
        end
    end

    // select the read lanes from the corrected word
    always @* begin
        if (rd_high_q) begin
            rd_sel = (rd_byte_q && rd_odd_q) ? 16'h0000 : {8'h00, dec_data[23:16]};
        end else if (!rd_byte_q) begin
            rd_sel = dec_data[15:0];
        end else begin
            rd_sel = rd_odd_q ? {8'h00, dec_data[15:8]} : {8'h00, dec_data[7:0]};
        end
    end

    // two-cycle completion for both reads and writes
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_pend_q   <= 1'b0;
            rd_pend_q   <= 1'b0;
            rd_high_q   <= 1'b0;
            rd_byte_q   <= 1'b0;
            rd_odd_q    <= 1'b0;
            o_tbl_done  <= 1'b0;
            o_tbl_rdata <= 16'h0000;
            o_ecc_trap  <= 1'b0;
        end else begin
            wr_pend_q  <= tbl_take && i_tbl_wr;
            rd_pend_q  <= tbl_take && !i_tbl_wr;
            o_tbl_done <= wr_pend_q || rd_pend_q;
            o_ecc_trap <= rd_pend_q && dec_double;
            if (tbl_take) begin
                rd_high_q <= i_tbl_high;
                rd_byte_q <= i_tbl_byte;
                rd_odd_q  <= tbl_addr[0];
            end
            if (rd_pend_q) begin
                // corrected data goes to the core only, array untouched
                o_tbl_rdata <= rd_sel;
            end
        end
    end

    // ****************************************************************
    // ecc coder shared by program and read paths
    // ****************************************************************
    fsp_ecc u_ecc (
        .i_enc_data   (latch_mem[idx_q]),
        .o_enc_check  (enc_chk),
        .i_dec_word   (i_arr_rdata),
        .o_dec_data   (dec_data),
        .o_dec_single (dec_single),
        .o_dec_double (dec_double)
    );

    // ****************************************************************
    // self-timed program and erase sequencer
    // ****************************************************************
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q        <= ST_IDLE;
            start_q     <= 1'b0;
            idx_q       <= 7'h00;
            left_q      <= 7'h00;
            wait_q      <= 16'h0000;
            o_arr_addr  <= 23'h000000;
            o_arr_wdata <= 31'h00000000;
            o_arr_prog  <= 1'b0;
            o_arr_read  <= 1'b0;
            o_arr_erase <= 1'b0;
            o_arr_chip  <= 1'b0;
        end else begin
            o_arr_prog <= 1'b0;
            o_arr_read <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (tbl_take && !i_tbl_wr) begin
                        o_arr_addr <= tbl_addr[23:1];
                        o_arr_read <= 1'b1;
                    end
                    if (launch) begin
                        start_q <= 1'b1;
                        case (i_pwdata[3:0])
                            `FSP_OP_ROW: begin
                                // row base: low offset bits dropped
                                o_arr_addr <= {target[23:8], 7'h00};
                                idx_q      <= 7'h00;
                                left_q     <= ROW_LAST[6:0];
                                st_q       <= ST_PGM;
                            end
                            `FSP_OP_DWORD: begin
                                o_arr_addr <= {target[23:2], 1'b0};
                                idx_q      <= {target[7:2], 1'b0};
                                left_q     <= 7'h01;
                                st_q       <= ST_PGM;
                            end
                            `FSP_OP_ERASE: begin
                                // eight-row block, aligned from address zero
                                o_arr_addr  <= {target[23:11], 10'h000};
                                o_arr_erase <= 1'b1;
                                wait_q      <= ERASE_LAST[15:0];
                                st_q        <= ST_ERASE;
                            end
                            default: begin
                                o_arr_chip <= 1'b1;
                                wait_q     <= ERASE_LAST[15:0];
                                st_q       <= ST_ERASE;
                            end
                        endcase
                    end
                end
                ST_PGM: begin
                    // data and its check bits go out in one strobe
                    o_arr_wdata <= {enc_chk, latch_mem[idx_q]};
                    o_arr_prog  <= 1'b1;
                    wait_q      <= PGM_LAST[15:0];
                    st_q        <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (wait_q != 16'h0000) begin
                        wait_q <= wait_q - 16'h0001;
                    end else if (left_q != 7'h00) begin
                        left_q     <= left_q - 7'h01;
                        idx_q      <= idx_q + 7'h01;
                        o_arr_addr <= o_arr_addr + 23'h000001;
                        st_q       <= ST_PGM;
                    end else begin
                        start_q <= 1'b0;
                        st_q    <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    if (wait_q != 16'h0000) begin
                        wait_q <= wait_q - 16'h0001;
                    end else begin
                        o_arr_erase <= 1'b0;
                        o_arr_chip  <= 1'b0;
                        start_q     <= 1'b0;
                        st_q        <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

endmodule // fsp_ctrl

// [fsp_defs.vh]
// constants for the flash self-programming controller
// ****************************************************************
// Contract
// - program one 128-word row per operation
// - erase blocks of eight rows, 1024 words
// - seven-bit ecc computed on write, checked on read
// - ecc bits programmed together with their data
// - single error corrected silently, double error traps
// - address is page field joined to offset
// - low-word ops reach bits 15..0, word/byte
// - high-word ops reach bits 23..16, word/byte
// - blocks and rows aligned from memory start
// - table writes land in latches only
// - any latch count programs; 128 fill row
// - latches load in any order, last wins
// - table write takes two cycles
// - double-word programming also supported
// - each row programmed separately; latches never program
// - table ops reach program space in normal mode
// - start bit runs self-timed op, then clears
// - op codes: 0011 erase, 0010 row, 0001 dword, 1110 chip
// - permit bit needed; bad attempt sets error flag
// ****************************************************************
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// register byte offsets
`define FSP_OFS_CTRL      8'h00
`define FSP_OFS_KEY       8'h04
`define FSP_OFS_TGT_LO    8'h08
`define FSP_OFS_TGT_UP    8'h0C
`define FSP_OFS_PAGE      8'h10
`define FSP_OFS_ECC       8'h14

// control register fields
`define FSP_CTRL_START    15
`define FSP_CTRL_PERMIT   14
`define FSP_CTRL_ERR      13
`define FSP_CTRL_OP_HI    3

// unlock key values
`define FSP_KEY_FIRST     8'h55
`define FSP_KEY_SECOND    8'hAA

// operation codes
`define FSP_OP_ERASE      4'h3
`define FSP_OP_ROW        4'h2
`define FSP_OP_DWORD      4'h1
`define FSP_OP_CHIP       4'hE

// ecc status fields
`define FSP_ECC_FIX       0
`define FSP_ECC_DBL       1

// timing: clock period and self-timed durations in ns
`define FSP_CLK_NS        50
`define FSP_PGM_WORD_NS   20000
`define FSP_ERASE_NS      100000

// reset values
`define FSP_RST_WORD      32'h0000_0000
`endif

// [fsp_ecc.v]
// seven-bit sec-ded code for one 24-bit program word
module fsp_ecc (
    // encoder side
    input  wire [23:0] i_enc_data,
    output wire [6:0]  o_enc_check,
    // decoder side
    input  wire [30:0] i_dec_word,
    output wire [23:0] o_dec_data,
    output wire        o_dec_single,
    output wire        o_dec_double
);

    // ****************************************************************
    // position code of each data bit: 33..56, never a power of two
    // ****************************************************************
    function [23:0] mask_of;
        input integer j;
        integer i;
        integer p;
        begin
            mask_of = 24'h000000;
            for (i = 0; i < 24; i = i + 1) begin
                p          = 33 + i;
                mask_of[i] = p[j];
            end
        end
    endfunction

    wire [5:0]  enc_syn;
    wire [5:0]  dec_syn;
    wire [23:0] dec_raw;
    wire        dec_par;

    assign dec_raw = i_dec_word[23:0];

    // hamming check bits, one per position bit
    genvar j;
    generate
        for (j = 0; j < 6; j = j + 1) begin : g_chk
            assign enc_syn[j] = ^(i_enc_data & mask_of(j));
            assign dec_syn[j] = (^(dec_raw & mask_of(j))) ^ i_dec_word[24 + j];
        end
    endgenerate

    // overall parity is the seventh bit
    assign o_enc_check = {^{i_enc_data, enc_syn}, enc_syn};
    assign dec_par     = ^i_dec_word;

    // flip the data bit whose position matches the syndrome
    genvar i;
    generate
        for (i = 0; i < 24; i = i + 1) begin : g_fix
            assign o_dec_data[i] = dec_raw[i] ^ (dec_par && (dec_syn == (33 + i)));
        end
    endgenerate

    assign o_dec_single = dec_par;
    assign o_dec_double = !dec_par && (dec_syn != 6'h00);

endmodule // fsp_ecc

// [fsp_arr_model.sv]
// behavioural flash array facing the controller's array port
module fsp_arr_model (
    // array port from the controller
    input  wire        i_ref_clk,
    input  wire [22:0] i_addr,
    input  wire [30:0] i_wdata,
    input  wire        i_prog,
    input  wire        i_read,
    input  wire        i_erase,
    input  wire        i_chip,
    // bit errors injected into read data
    input  wire [30:0] i_flip,
    output wire [30:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [30:0] mem [4096];
    logic [30:0] last_q = 31'h0;
    initial foreach (mem[k]) mem[k] = 31'h7FFFFFFF;
    // outside a read cycle the lines show the inverse of the last value
    // the read is combinational while the read strobe stands
    assign o_rdata = i_read ? (mem[i_addr[11:0]] ^ i_flip) : ~last_q;
    // word and check bits land together; erase acts on 1024-word blocks
    always @(posedge i_ref_clk) begin
        if (i_read) last_q <= o_rdata;
        if (i_prog) mem[i_addr[11:0]] <= i_wdata;
        if (i_erase) for (int k = 0; k < 1024; k++) mem[{i_addr[11:10], 10'h000} | k] <= '1;
        if (i_chip) foreach (mem[k]) mem[k] <= 31'h7FFFFFFF;
    end
endmodule // fsp_arr_model

// [fsp_ctrl_chk.sv]
// port assertions for the flash self-programming controller
module fsp_ctrl_chk #(
    parameter ERASE_CYC = 8
) (
    input wire        i_ref_clk,
    input wire        i_rst,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [7:0]  i_paddr,
    input wire [31:0] i_pwdata,
    input wire        o_tbl_done,
    input wire        o_ecc_trap,
    input wire        o_cpu_stall,
    input wire        o_arr_prog,
    input wire        o_arr_read,
    input wire        o_arr_erase,
    input wire        o_arr_chip
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] ers_q;
    // length of the current erase level
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) ers_q <= 16'h0000;
        else ers_q <= o_arr_erase ? ers_q + 16'h0001 : 16'h0000;
    end
    logic        start_wr_q;
    // a permitted start write seen in the previous cycle
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) start_wr_q <= 1'b0;
        else start_wr_q <= i_psel && i_penable && i_pwrite && i_paddr == 8'h00
            && i_pwdata[15] && i_pwdata[14];
    end
    property p_rd_done; o_arr_read |=> o_tbl_done; endproperty
    a_rd_done: assert property (p_rd_done) else $error("read not done in time");
    property p_done_pls; o_tbl_done |=> !o_tbl_done; endproperty
    a_done_pls: assert property (p_done_pls) else $error("done longer than a cycle");
    property p_trap; o_ecc_trap |-> o_tbl_done; endproperty
    a_trap: assert property (p_trap) else $error("trap apart from done");
    property p_arr_stall; (o_arr_prog || o_arr_erase || o_arr_chip) |-> o_cpu_stall; endproperty
    a_arr_stall: assert property (p_arr_stall) else $error("array change while idle");
    property p_start; $rose(o_cpu_stall) |-> start_wr_q; endproperty
    a_start: assert property (p_start) else $error("stall without start write");
    property p_stall_end; $rose(o_cpu_stall) |-> ##[1:1000] !o_cpu_stall; endproperty
    a_stall_end: assert property (p_stall_end) else $error("operation never ends");
    property p_ers_len; $fell(o_arr_erase) |-> ers_q == ERASE_CYC; endproperty
    a_ers_len: assert property (p_ers_len) else $error("erase length wrong");
    property p_rd_noprog; o_arr_read |-> !o_arr_prog; endproperty
    a_rd_noprog: assert property (p_rd_noprog) else $error("read rewrote array");
    c_prog: cover property (o_arr_prog ##1 !o_arr_prog);
    c_erase: cover property ($fell(o_arr_erase));
    c_trap: cover property (o_ecc_trap);
endmodule // fsp_ctrl_chk
bind fsp_ctrl fsp_ctrl_chk #(.ERASE_CYC(ERASE_CYC)) i_fsp_ctrl_chk (.*);

// [fsp_ctrl_bench.sv]
// self-checking bench for the flash self-programming controller
`include "fsp_defs.vh"
`define FSP_CMP(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR %0t got %h exp %h", $time, a, e); end end
module fsp_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_ref_clk = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0;
    logic        i_pwrite = 1'h0, i_tbl_req = 1'h0, i_tbl_wr = 1'h0;
    logic        i_tbl_high = 1'h0, i_tbl_byte = 1'h0, err, trap;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, rd, b;
    logic [15:0] i_tbl_ea = 16'h0, i_tbl_wdata = 16'h0;
    logic [30:0] flip = 31'h0;
    logic [23:0] lat [128];
    wire         o_pready, o_pslverr, o_tbl_done, o_ecc_trap, o_cpu_stall;
    wire         o_arr_prog, o_arr_read, o_arr_erase, o_arr_chip;
    wire  [31:0] o_prdata;
    wire  [15:0] o_tbl_rdata;
    wire  [22:0] o_arr_addr;
    wire  [30:0] o_arr_wdata, i_arr_rdata;
    int          n_errors = 0, checks_done = 0, k;
    always #25 i_ref_clk = ~i_ref_clk;
    fsp_ctrl #(.PGM_CYC(4), .ERASE_CYC(8)) i_fsp_ctrl (.*);
    fsp_arr_model i_fsp_arr_model (.i_ref_clk, .i_addr(o_arr_addr), .i_wdata(o_arr_wdata),
        .i_prog(o_arr_prog), .i_read(o_arr_read), .i_erase(o_arr_erase), .i_chip(o_arr_chip),
        .i_flip(flip), .o_rdata(i_arr_rdata));
    task stop_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task hang;
        n_errors++;
        $display("ERROR %0t wait ran out", $time);
        stop_test;
    endtask
    // one apb transfer; data and error taken at the ready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_ref_clk);
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'h1;
        for (n = 0; n < 20; n++) begin
            @(posedge i_ref_clk);
            if (o_pready === 1'h1) break;
        end
        if (n == 20) hang;
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask
    // one table operation, waits for done
    task tbl(input logic w, h, y, input logic [15:0] ea, wd);
        int n;
        @(posedge i_ref_clk);
        {i_tbl_req, i_tbl_wr, i_tbl_high, i_tbl_byte} <= {1'h1, w, h, y};
        i_tbl_ea <= ea;
        i_tbl_wdata <= wd;
        @(posedge i_ref_clk);
        i_tbl_req <= 1'h0;
        for (n = 0; n < 10 && o_tbl_done !== 1'h1; n++) @(negedge i_ref_clk);
        if (n == 10) hang;
        trap = o_ecc_trap;
        `FSP_CMP(n, 2)
    endtask
    task load(input int i);
        lat[i] = 24'($urandom);
        tbl(1, 0, 0, 16'(2 * i), lat[i][15:0]);
        tbl(1, 1, 0, 16'(2 * i), {8'h0, lat[i][23:16]});
    endtask
    task chk_word(input logic [23:0] a, e);
        tbl(0, 0, 0, a[15:0], 16'h0);
        `FSP_CMP(o_tbl_rdata, e[15:0])
        tbl(0, 1, 0, a[15:0], 16'h0);
        `FSP_CMP(o_tbl_rdata, {8'h0, e[23:16]})
    endtask
    // target, optional unlock, start; then watch the stall and the flags
    task run(input logic [15:0] ctl, input logic [23:0] t, input logic key, ok);
        int n;
        logic seen;
        seen = 1'h0;
        apb(1, `FSP_OFS_TGT_LO, {16'h0, t[15:0]});
        apb(1, `FSP_OFS_TGT_UP, {24'h0, t[23:16]});
        if (key) apb(1, `FSP_OFS_KEY, 32'h55);
        if (key) apb(1, `FSP_OFS_KEY, 32'hAA);
        apb(1, `FSP_OFS_CTRL, {16'h0, ctl});
        for (n = 0; n < 3000; n++) begin
            @(negedge i_ref_clk);
            seen = seen | o_cpu_stall;
            if (n > 4 && o_cpu_stall === 1'h0) break;
        end
        if (n == 3000) hang;
        `FSP_CMP(seen, ok)
        apb(0, `FSP_OFS_CTRL, 0);
        `FSP_CMP({rd[15:13], rd[3:0]}, {1'h0, ctl[14], !ok, ctl[3:0]})
    endtask
    initial begin
        void'($urandom(32'hA4F48F3F));
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'h0;
        apb(0, `FSP_OFS_CTRL, 0);
        `FSP_CMP(rd, 32'h0)
        apb(0, 8'h18, 0);
        `FSP_CMP({err, rd}, {1'h1, 32'h0})
        apb(1, `FSP_OFS_PAGE, 0);
        $display("test registers done");
        // every latch loaded, top down, then one byte rewritten
        for (k = 127; k >= 0; k--) load(k);
        b = $urandom;
        tbl(1, 0, 1, 16'h000B, {8'h0, b[7:0]});
        lat[5][15:8] = b[7:0];
        run(16'hC002, 24'h000346, 1, 1);
        for (k = 0; k < 128; k++) chk_word(24'h000300 + 24'(2 * k), lat[k]);
        $display("test row program done");
        // one flipped bit is corrected, two trap, stored word untouched
        b = $urandom_range(30);
        flip = 31'h1 << b;
        chk_word(24'h000310, lat[8]);
        `FSP_CMP(trap, 1'h0)
        flip = flip | (31'h1 << ((b + 1) % 31));
        tbl(0, 0, 0, 16'h0310, 16'h0);
        `FSP_CMP(trap, 1'h1)
        apb(0, `FSP_OFS_ECC, 0);
        `FSP_CMP(rd[1:0], 2'h3)
        apb(1, `FSP_OFS_ECC, 32'h3);
        apb(0, `FSP_OFS_ECC, 0);
        `FSP_CMP(rd[1:0], 2'h0)
        flip = 31'h0;
        chk_word(24'h000310, lat[8]);
        run(16'hC002, 24'h000300, 0, 0);
        run(16'h8002, 24'h000300, 1, 0);
        run(16'hC004, 24'h000300, 1, 0);
        $display("test refusals done");
        for (k = 4; k < 6; k++) load(k);
        run(16'hC001, 24'h000808, 1, 1);
        run(16'hC003, 24'h000654, 1, 1);
        `FSP_CMP(i_fsp_arr_model.mem[12'h180], 31'h7FFFFFFF)
        chk_word(24'h000808, lat[4]);
        chk_word(24'h00080A, lat[5]);
        run(16'hC00E, 24'h000000, 1, 1);
        `FSP_CMP(i_fsp_arr_model.mem[12'h404], 31'h7FFFFFFF)
        $display("test erase done");
        stop_test;
    end
endmodule // fsp_ctrl_bench
